/* File: common/dsg_regs.svh */
// Register offsets, field positions, reset values and masks of the deep-sleep clock gating block
`ifndef DSG_REGS_SVH
`define DSG_REGS_SVH

`define DSG_ADDR_W 12
`define DSG_OFF_DEEP_GATE 12'h124
`define DSG_OFF_RUN_GATE 12'h200
`define DSG_OFF_SLEEP_GATE 12'h204
`define DSG_OFF_RUN_CONFIG 12'h208
`define DSG_OFF_STATUS 12'h210
`define DSG_OFF_CLEAR 12'h214
`define DSG_OFF_ENABLE 12'h218
`define DSG_OFF_MODE 12'h21C

`define DSG_GATE_RESET 32'h0000_0000
`define DSG_GATE_MASK 32'h0707_1013
`define DSG_CONFIG_RESET 32'h0000_0000
`define DSG_BIT_AUTO_GATING 0

`define DSG_BIT_CMP2 26
`define DSG_BIT_CMP1 25
`define DSG_BIT_CMP0 24
`define DSG_BIT_CNT2 18
`define DSG_BIT_CNT1 17
`define DSG_BIT_CNT0 16
`define DSG_BIT_TWI0 12
`define DSG_BIT_SYN0 4
`define DSG_BIT_ASY1 1
`define DSG_BIT_ASY0 0

`define DSG_NUM_UNITS 10
`define DSG_UNIT_IDX_W 4
`define DSG_NUM_EVENTS 4
`define DSG_EVT_FAULT 0
`define DSG_EVT_DEEP_ENTER 1
`define DSG_EVT_DEEP_EXIT 2
`define DSG_EVT_SLEEP_ENTER 3
`define DSG_EVT_MASK 32'h0000_000F
`define DSG_RESET_IRQ 32'h0000_0000

`endif

/* File: common/dsg_pkg.sv */
// Types shared by the deep-sleep clock gating block
package dsg_pkg;
  `include "dsg_regs.svh"

  typedef enum logic [2:0] {
    DSG_RUN = 3'b001,
    DSG_SLEEP = 3'b010,
    DSG_DEEP = 3'b100
  } dsg_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`DSG_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } dsg_apb_req_t;

  typedef struct packed {
    logic valid;
    logic [`DSG_UNIT_IDX_W-1:0] unit;
  } dsg_unit_req_t;

  typedef struct packed {
    logic done;
    logic fault;
  } dsg_unit_rsp_t;
endpackage

/* File: hdl/dsg_fault_check.sv */
// Access checker that faults accesses to unclocked units
`timescale 1ns/1ps
`include "dsg_regs.svh"
module dsg_fault_check
  import dsg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [`DSG_NUM_UNITS-1:0] clkEn,
  input wire dsg_pkg::dsg_unit_req_t req,
  output dsg_pkg::dsg_unit_rsp_t rsp
);
  dsg_unit_rsp_t rsp_ff;
  logic selEn;
  logic inRange;

  // Indices beyond the unit count have no clock at all and fault too
  assign inRange = req.unit < `DSG_UNIT_IDX_W'(`DSG_NUM_UNITS);
  assign selEn = inRange && clkEn[req.unit];

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.done <= req.valid;
      rsp_ff.fault <= req.valid && !selEn;
    end
  end

  assign rsp = rsp_ff;
endmodule // dsg_fault_check

/* File: hdl/dsg_clock_gate.sv */
// Deep-sleep clock gating register block with APB slave and unit clock enables
// Behaviour
// - set bit clocks unit, clear bit stops it
// - access to unclocked unit returns bus fault
// - reset clears the gating register to zero
// - gating register sits at offset 0x124
// - register governs gating during deep-sleep
// - sleep registers used only with auto gating
// - comparator enables at bits 26, 25, 24
// - counter enables at bits 18, 17, 16
// - two-wire serial enable at bit 12
// - synchronous serial enable at bit 4
// - asynchronous serial enables at bits 1, 0
// - reserved fields read-only, read as zero
`timescale 1ns/1ps
`include "dsg_regs.svh"
module dsg_clock_gate
  import dsg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire dsg_pkg::dsg_apb_req_t apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleepReq,
  input wire logic deepSleepReq,
  input wire dsg_pkg::dsg_unit_req_t unitReq,
  output logic unitDone,
  output logic unitFault,
  output logic [`DSG_NUM_UNITS-1:0] unitClkEn,
  output logic irq
);
  import dsg_pkg::*;

  logic [31:0] deepGate_ff;
  logic [31:0] runGate_ff;
  logic [31:0] sleepGate_ff;
  logic autoGating_ff;
  logic [`DSG_NUM_EVENTS-1:0] status_ff;
  logic [`DSG_NUM_EVENTS-1:0] irqEn_ff;
  dsg_mode_t mode_ff;
  dsg_mode_t nxt_mode;
  logic [`DSG_NUM_UNITS-1:0] unitClkEn_ff;
  logic [`DSG_NUM_UNITS-1:0] nxt_unitClkEn;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic pready_ff;
  logic pslverr_ff;
  logic nxt_pslverr;
  logic irq_ff;
  logic unitDone_ff;
  logic unitFault_ff;
  logic access;
  logic wrStb;
  logic hit;
  logic [31:0] activeGate;
  logic [`DSG_NUM_EVENTS-1:0] events;
  logic [`DSG_NUM_EVENTS-1:0] clrBits;
  dsg_unit_rsp_t chkRsp;

  // Register bit of each unit, in unit index order
  localparam int unsigned UnitBit [`DSG_NUM_UNITS] = '{
    `DSG_BIT_ASY0, `DSG_BIT_ASY1, `DSG_BIT_SYN0, `DSG_BIT_TWI0,
    `DSG_BIT_CNT0, `DSG_BIT_CNT1, `DSG_BIT_CNT2,
    `DSG_BIT_CMP0, `DSG_BIT_CMP1, `DSG_BIT_CMP2
  };

  // One wait state: the answer is registered so all outputs come from flops
  assign access = apbReq.psel && apbReq.penable && !pready_ff;
  assign wrStb = access && apbReq.pwrite;

  always_comb begin
    hit = 1'b1;
    nxt_prdata = 32'h0000_0000;
    unique case (apbReq.paddr)
      `DSG_OFF_DEEP_GATE: nxt_prdata = deepGate_ff & `DSG_GATE_MASK;
      `DSG_OFF_RUN_GATE: nxt_prdata = runGate_ff & `DSG_GATE_MASK;
      `DSG_OFF_SLEEP_GATE: nxt_prdata = sleepGate_ff & `DSG_GATE_MASK;
      `DSG_OFF_RUN_CONFIG: nxt_prdata[`DSG_BIT_AUTO_GATING] = autoGating_ff;
      `DSG_OFF_STATUS: nxt_prdata[`DSG_NUM_EVENTS-1:0] = status_ff;
      `DSG_OFF_CLEAR: nxt_prdata = 32'h0000_0000;
      `DSG_OFF_ENABLE: nxt_prdata[`DSG_NUM_EVENTS-1:0] = irqEn_ff;
      `DSG_OFF_MODE: nxt_prdata[2:0] = mode_ff;
      default: hit = 1'b0;
    endcase
    if (apbReq.pwrite) begin
      nxt_prdata = 32'h0000_0000;
    end
    // Read-only status and unmapped offsets answer with an error
    nxt_pslverr = !hit || (apbReq.pwrite && apbReq.paddr == `DSG_OFF_STATUS);
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= access;
      prdata_ff <= access ? nxt_prdata : 32'h0000_0000;
      pslverr_ff <= access && nxt_pslverr;
    end
  end

  // Only writable bits are stored, so reserved bits cannot leak back
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      deepGate_ff <= `DSG_GATE_RESET;
    end else if (wrStb && apbReq.paddr == `DSG_OFF_DEEP_GATE) begin
      deepGate_ff <= apbReq.pwdata & `DSG_GATE_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      runGate_ff <= `DSG_GATE_RESET;
    end else if (wrStb && apbReq.paddr == `DSG_OFF_RUN_GATE) begin
      runGate_ff <= apbReq.pwdata & `DSG_GATE_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sleepGate_ff <= `DSG_GATE_RESET;
    end else if (wrStb && apbReq.paddr == `DSG_OFF_SLEEP_GATE) begin
      sleepGate_ff <= apbReq.pwdata & `DSG_GATE_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      autoGating_ff <= 1'b0;
    end else if (wrStb && apbReq.paddr == `DSG_OFF_RUN_CONFIG) begin
      autoGating_ff <= apbReq.pwdata[`DSG_BIT_AUTO_GATING];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irqEn_ff <= '0;
    end else if (wrStb && apbReq.paddr == `DSG_OFF_ENABLE) begin
      irqEn_ff <= apbReq.pwdata[`DSG_NUM_EVENTS-1:0];
    end
  end

  // Deep-sleep takes priority when both requests are high
  always_comb begin
    if (deepSleepReq) begin
      nxt_mode = DSG_DEEP;
    end else if (sleepReq) begin
      nxt_mode = DSG_SLEEP;
    end else begin
      nxt_mode = DSG_RUN;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mode_ff <= DSG_RUN;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // Without auto gating the run register holds in every mode
  always_comb begin
    activeGate = runGate_ff;
    if (autoGating_ff) begin
      unique case (mode_ff)
        DSG_RUN: activeGate = runGate_ff;
        DSG_SLEEP: activeGate = sleepGate_ff;
        DSG_DEEP: activeGate = deepGate_ff;
      endcase
    end
  end

  for (genvar u = 0; u < `DSG_NUM_UNITS; u++) begin : gUnit
    assign nxt_unitClkEn[u] = activeGate[UnitBit[u]];
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      unitClkEn_ff <= '0;
    end else begin
      unitClkEn_ff <= nxt_unitClkEn;
    end
  end

  dsg_fault_check uChk (
    .mclk(mclk),
    .rst_b(rst_b),
    .clkEn(unitClkEn_ff),
    .req(unitReq),
    .rsp(chkRsp)
  );

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      unitDone_ff <= 1'b0;
      unitFault_ff <= 1'b0;
    end else begin
      unitDone_ff <= chkRsp.done && !chkRsp.fault;
      unitFault_ff <= chkRsp.fault;
    end
  end

  always_comb begin
    events = '0;
    events[`DSG_EVT_FAULT] = chkRsp.fault;
    events[`DSG_EVT_DEEP_ENTER] = nxt_mode == DSG_DEEP && mode_ff != DSG_DEEP;
    events[`DSG_EVT_DEEP_EXIT] = nxt_mode != DSG_DEEP && mode_ff == DSG_DEEP;
    events[`DSG_EVT_SLEEP_ENTER] = nxt_mode == DSG_SLEEP && mode_ff != DSG_SLEEP;
  end

  assign clrBits = (wrStb && apbReq.paddr == `DSG_OFF_CLEAR) ?
    apbReq.pwdata[`DSG_NUM_EVENTS-1:0] : '0;

  // A new event in the clearing cycle keeps its bit set
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      status_ff <= '0;
    end else begin
      status_ff <= (status_ff & ~clrBits) | events;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(((status_ff & ~clrBits) | events) & irqEn_ff);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign unitDone = unitDone_ff;
  assign unitFault = unitFault_ff;
  assign unitClkEn = unitClkEn_ff;
  assign irq = irq_ff;
endmodule // dsg_clock_gate

/* File: sim/dsg_clock_gate_sva.sv */
// Assertion checker for the deep-sleep clock gating block
`timescale 1ns/1ps
`include "dsg_regs.svh"
module dsg_clock_gate_sva
  import dsg_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire dsg_pkg::dsg_apb_req_t apbReq,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleepReq,
  input wire logic deepSleepReq,
  input wire dsg_pkg::dsg_unit_req_t unitReq,
  input wire logic unitDone,
  input wire logic unitFault,
  input wire logic [`DSG_NUM_UNITS-1:0] unitClkEn,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  apb_answer_a:
  assert property (apbReq.psel && apbReq.penable && !pready |=> pready ##1 !pready)
    else $error("apb answer timing");
  deep_mapped_a:
  assert property (pready && apbReq.paddr == `DSG_OFF_DEEP_GATE |-> !pslverr)
    else $error("gate register refused");
  reserved_zero_a:
  assert property (pready && !apbReq.pwrite && apbReq.paddr == `DSG_OFF_DEEP_GATE
    |-> (prdata & ~`DSG_GATE_MASK) == 32'h0) else $error("reserved bits set");
  gate_reset_a:
  assert property (!$past(rst_b) |-> unitClkEn == '0) else $error("enables after reset");
  fault_off_a:
  assert property (unitReq.valid && !unitClkEn[unitReq.unit] |-> ##2 unitFault)
    else $error("no fault on gated unit");
  done_on_a:
  assert property (unitReq.valid && unitReq.unit < 4'hA && unitClkEn[unitReq.unit]
    |-> ##2 unitDone && !unitFault) else $error("clocked unit refused");
  bad_index_a:
  assert property (unitReq.valid && unitReq.unit >= 4'hA |-> ##2 unitFault)
    else $error("bad index not faulted");
  answer_cause_a:
  assert property (unitDone || unitFault |-> $past(unitReq.valid, 2))
    else $error("answer without access");
  cover property (unitFault);
  cover property (unitDone);
  cover property (pready && pslverr);
endmodule // dsg_clock_gate_sva
bind dsg_clock_gate dsg_clock_gate_sva i_dsg_clock_gate_sva (
  .mclk(mclk),
  .rst_b(rst_b),
  .apbReq(apbReq),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .sleepReq(sleepReq),
  .deepSleepReq(deepSleepReq),
  .unitReq(unitReq),
  .unitDone(unitDone),
  .unitFault(unitFault),
  .unitClkEn(unitClkEn),
  .irq(irq)
);

/* File: sim/dsg_unit_model.sv */
// Bus-side model issuing accesses to the gated peripheral units
`timescale 1ns/1ps
module dsg_unit_model
  import dsg_pkg::*;
(
  input wire logic mclk,
  output dsg_pkg::dsg_unit_req_t unitReq
);
  initial unitReq = '0;
  // One idle edge before each pulse keeps calls in a row from merging
  task automatic access(input logic [3:0] u, input int gap);
    repeat (gap + 1) @(posedge mclk);
    unitReq <= '{valid: 1'b1, unit: u};
    @(posedge mclk);
    unitReq <= '0;
  endtask
endmodule // dsg_unit_model

/* File: sim/tb_top.sv */
// Self-checking bench for the deep-sleep clock gating block
`timescale 1ns/1ps
`include "dsg_regs.svh"
module tb_top;
  import dsg_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  dsg_apb_req_t apbReq = '0;
  logic sleepReq = 1'b0;
  logic deepSleepReq = 1'b0;
  dsg_unit_req_t unitReq;
  logic [31:0] prdata;
  logic pready, pslverr, unitDone, unitFault, irq, u;
  logic [`DSG_NUM_UNITS-1:0] unitClkEn;
  int errors = 0;
  int checks_done = 0;
  logic [33:0] apbQ[$];
  logic [33:0] e;
  logic unitQ[$];
  logic [31:0] r;
  logic [3:0] uu[4] = '{4'h3, 4'h4, 4'hC, 4'h0};
  always #5 mclk = ~mclk;
  dsg_clock_gate i_dsg_clock_gate (.mclk(mclk), .rst_b(rst_b), .apbReq(apbReq), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleepReq(sleepReq), .deepSleepReq(deepSleepReq),
    .unitReq(unitReq), .unitDone(unitDone), .unitFault(unitFault), .unitClkEn(unitClkEn),
    .irq(irq));
  dsg_unit_model i_dsg_unit_model (.mclk(mclk), .unitReq(unitReq));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Expectation is queued first, the monitor compares when pready shows
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] exp, input logic err);
    int n;
    apbQ.push_back({!wr, err, exp});
    @(posedge mclk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge mclk);
    if (n == 20) begin
      errors++;
      close_out();
    end
    apbReq <= '0;
  endtask
  task automatic settle();
    repeat (4) @(posedge mclk);
  endtask
  always @(posedge mclk) begin
    if (pready === 1'b1) begin
      e = apbQ.pop_front();
      check("pslverr", 32'(pslverr), 32'(e[32]));
      if (e[33]) check("prdata", prdata, e[31:0]);
    end
    if (unitDone === 1'b1 || unitFault === 1'b1) begin
      u = unitQ.pop_front();
      check("unitFault", 32'(unitFault), 32'(u));
      check("unitDone", 32'(unitDone), 32'(!u));
    end
  end
  initial begin
    void'($urandom(32'hFD4D1134));
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    apb(1'b0, `DSG_OFF_DEEP_GATE, 32'h0, `DSG_GATE_RESET, 1'b0);
    for (int i = 0; i < 5; i++) begin
      r = (i == 0) ? 32'hFFFF_FFFF : $urandom();
      apb(1'b1, `DSG_OFF_DEEP_GATE, r, 32'h0, 1'b0);
      apb(1'b0, `DSG_OFF_DEEP_GATE, 32'h0, r & `DSG_GATE_MASK, 1'b0);
    end
    apb(1'b1, `DSG_OFF_DEEP_GATE, (r & `DSG_GATE_MASK) | 32'h0000_1000, 32'h0, 1'b0);
    apb(1'b0, `DSG_OFF_DEEP_GATE, 32'h0, (r & `DSG_GATE_MASK) | 32'h0000_1000, 1'b0);
    apb(1'b0, 12'h120, 32'h0, 32'h0, 1'b1);
    apb(1'b1, `DSG_OFF_STATUS, 32'h1, 32'h0, 1'b1);
    apb(1'b1, `DSG_OFF_RUN_GATE, 32'h2, 32'h0, 1'b0);
    apb(1'b1, `DSG_OFF_SLEEP_GATE, 32'h10, 32'h0, 1'b0);
    apb(1'b1, `DSG_OFF_DEEP_GATE, 32'h1001, 32'h0, 1'b0);
    deepSleepReq <= 1'b1;
    settle();
    check("clk no auto", 32'(unitClkEn), 32'h2);
    apb(1'b1, `DSG_OFF_RUN_CONFIG, 32'h1, 32'h0, 1'b0);
    settle();
    check("clk deep", 32'(unitClkEn), 32'h9);
    foreach (uu[k]) begin
      unitQ.push_back(uu[k] != 4'h3 && uu[k] != 4'h0);
      i_dsg_unit_model.access(uu[k], k);
    end
    deepSleepReq <= 1'b0;
    sleepReq <= 1'b1;
    settle();
    check("clk sleep", 32'(unitClkEn), 32'h4);
    sleepReq <= 1'b0;
    settle();
    check("clk run", 32'(unitClkEn), 32'h2);
    check("irq masked", 32'(irq), 32'h0);
    apb(1'b0, `DSG_OFF_STATUS, 32'h0, 32'h0000_000F, 1'b0);
    apb(1'b0, `DSG_OFF_MODE, 32'h0, 32'h0000_0001, 1'b0);
    apb(1'b1, `DSG_OFF_ENABLE, 32'h1, 32'h0, 1'b0);
    settle();
    check("irq on", 32'(irq), 32'h1);
    apb(1'b1, `DSG_OFF_CLEAR, 32'hF, 32'h0, 1'b0);
    settle();
    check("irq cleared", 32'(irq), 32'h0);
    apb(1'b0, `DSG_OFF_STATUS, 32'h0, 32'h0, 1'b0);
    apb(1'b1, `DSG_OFF_DEEP_GATE, 32'h0701_1013, 32'h0, 1'b0);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    apb(1'b0, `DSG_OFF_DEEP_GATE, 32'h0, `DSG_GATE_RESET, 1'b0);
    settle();
    check("clk reset", 32'(unitClkEn), 32'h0);
    check("answers left", 32'(unitQ.size() + apbQ.size()), 32'h0);
    close_out();
  end
endmodule // tb_top
